// >>> amc_pkg.sv
package amc_pkg;
	// register indices on the plain register port
	localparam logic [3:0] REG_MODE     = 4'h0; // operating mode and update rate
	localparam logic [3:0] REG_MAIN_CTL = 4'h1; // main converter control
	localparam logic [3:0] REG_AUX_CTL  = 4'h2; // auxiliary converter control
	localparam logic [3:0] REG_STATUS   = 4'h3; // ready, error and reference flags
	localparam logic [3:0] REG_DATA0    = 4'h4; // main conversion result
	localparam logic [3:0] REG_DATA1    = 4'h5; // auxiliary conversion result
	localparam logic [3:0] REG_OFS0     = 4'h6; // main offset coefficient
	localparam logic [3:0] REG_OFS1     = 4'h7; // auxiliary offset coefficient
	localparam logic [3:0] REG_GAIN0    = 4'h8; // main gain coefficient
	localparam logic [3:0] REG_GAIN1    = 4'h9; // auxiliary gain coefficient

	// field positions
	localparam int MODE_LSB   = 0; // op_mode_bit0 .. op_mode_bit2
	localparam int RATE_LSB   = 4; // programmed update rate field
	localparam int EN_BIT     = 0; // conv enable bit in each control register
	localparam int ST_RDY0    = 0; // channel_ready_flag, main
	localparam int ST_RDY1    = 1; // channel_ready_flag, auxiliary
	localparam int ST_ERR     = 2; // calibration_error_flag
	localparam int ST_NOREF   = 3; // reference_missing_flag

	localparam int MODE_W     = 3;  // operating-mode field width
	localparam int RATE_W     = 4;  // update rate field width
	localparam int NCH        = 2;  // main and auxiliary converters

	// reset values
	localparam logic [2:0] MODE_RST = 3'h0; // power-down after power-up
	localparam logic [3:0] RATE_RST = 4'h0; // fastest programmed rate
	localparam logic [3:0] RATE_SLOWEST = 4'hF; // rate used during calibration

	// converter states
	typedef enum logic [2:0] {
		AMC_PWRDN,
		AMC_IDLE,
		AMC_DISABLE,
		AMC_CONV,
		AMC_CAL
	} amc_state_t;
endpackage : amc_pkg

// >>> amc_ctrl.sv
// Overview of operation
// - mode code zero enters whole-device power-down
// - reset leaves device in power-down
// - each enable bit powers its own converter
// - registers hold value while powered down/disabled
// - register port works during power-down
// - power-down or idle forces ready line high
// - calibration end or single conversion returns idle
// - both enables clear: converters off, PLL on
// - four calibration codes select calibration kind
// - factory gain coefficients loaded at power-on
// - per-channel coefficients, calibration overwrites them
// - zero-scale to offset, full-scale to gain
// - internal calibration selects internal input source
// - calibration runs at slowest update rate
// - subtract offset, then multiply by gain
// - ready status bit marks calibration end
// - missing reference blocks update, sets error (code: calibration only; conversions store all ones, no error)
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module amc_ctrl #(
	parameter int         DW          = 24,     // filter and coefficient word width
	parameter logic [2:0] CODE_IDLE   = 3'h1,   // idle mode code
	parameter logic [2:0] CODE_CONT   = 3'h2,   // continuous conversion code
	parameter logic [2:0] CODE_SINGLE = 3'h3,   // single conversion code
	parameter logic [2:0] CODE_IZS    = 3'h4,   // internal zero-scale calibration
	parameter logic [2:0] CODE_IFS    = 3'h5,   // internal full-scale calibration
	parameter logic [2:0] CODE_SZS    = 3'h6,   // system zero-scale calibration
	parameter logic [2:0] CODE_SFS    = 3'h7,   // system full-scale calibration
	parameter logic [DW-1:0] FACT_GAIN0 = 24'h800000, // stored main gain, unity
	parameter logic [DW-1:0] FACT_GAIN1 = 24'h800000  // stored aux gain, unity
) (
	input  wire logic          i_core_clk,        // core clock, 40 MHz
	input  wire logic          i_rstn,            // async reset, active low
	input  wire logic [3:0]    i_addr,            // register index
	input  wire logic [31:0]   i_wdata,           // register write data
	input  wire logic          i_wr,              // write strobe
	input  wire logic          i_rd,              // read strobe
	output logic      [31:0]   o_rdata,           // read data, cycle after strobe
	input  wire logic [DW-1:0] i_main_filt_data,  // main filter output word
	input  wire logic          i_main_filt_valid, // main word strobe
	input  wire logic [DW-1:0] i_aux_filt_data,   // aux filter output word
	input  wire logic          i_aux_filt_valid,  // aux word strobe
	input  wire logic          i_ref_missing,     // reference detect pin, async
	output logic               o_rdy_n,           // data-ready line, active low
	output logic               o_main_pwr_en,     // main converter powered
	output logic               o_aux_pwr_en,      // aux converter powered
	output logic               o_pll_en,          // PLL running
	output logic               o_host_if_en,      // serial host interface alive
	output logic               o_int_zero_sel,    // internal zero input connected
	output logic               o_int_full_sel,    // internal full-scale input connected
	output logic      [3:0]    o_rate_sel         // update rate to the filter
);
	localparam int PW = 2 * DW + 1; // scaled product width

	logic [2:0]          mode_q;      // operating-mode field
	logic [3:0]          rate_q;      // programmed update rate
	logic [1:0]          en_q;        // conv enables, bit0 main, bit1 aux
	logic [1:0]          pend_q;      // channels still owing a word
	logic [1:0]          rdy_q;       // channel_ready_flag per channel
	logic                err_q;       // calibration_error_flag
	logic [1:0]          ref_sync_q;  // reference pin synchroniser
	logic [DW-1:0]       data_q [2];  // conversion results
	logic [DW-1:0]       ofs_q  [2];  // offset coefficients
	logic [DW-1:0]       gain_q [2];  // gain coefficients
	logic [DW-1:0]       filt   [2];  // filter words by channel
	logic [1:0]          fvalid;      // filter strobes by channel
	logic [DW-1:0]       scaled [2];  // corrected results
	logic [1:0]          take;        // word accepted this cycle
	logic [1:0]          rd_data;     // data register read this cycle
	logic [31:0]         rdata_d;     // read mux
	amc_pkg::amc_state_t state;       // decoded converter state
	logic                is_cal;      // any calibration code
	logic                is_zero;     // zero-scale calibration
	logic                is_int;      // internal calibration
	logic                noref;       // synchronised reference missing
	logic                wr_mode;     // mode register written
	logic                seq_done;    // last owed word arrives now

	assign filt[0]   = i_main_filt_data;
	assign filt[1]   = i_aux_filt_data;
	assign fvalid    = {i_aux_filt_valid, i_main_filt_valid};
	assign noref     = ref_sync_q[1];
	assign wr_mode   = i_wr && (i_addr == amc_pkg::REG_MODE);

	// decode calibration kind from the mode field
	assign is_cal  = (mode_q == CODE_IZS) || (mode_q == CODE_IFS) ||
	                 (mode_q == CODE_SZS) || (mode_q == CODE_SFS);
	assign is_zero = (mode_q == CODE_IZS) || (mode_q == CODE_SZS);
	assign is_int  = (mode_q == CODE_IZS) || (mode_q == CODE_IFS);

	// decode state from mode and enables
	always_comb begin
		if (mode_q == amc_pkg::MODE_RST) begin
			state = amc_pkg::AMC_PWRDN;
		end else if (en_q == 2'h0) begin
			state = amc_pkg::AMC_DISABLE;
		end else if (is_cal) begin
			state = amc_pkg::AMC_CAL;
		end else if ((mode_q == CODE_CONT) || (mode_q == CODE_SINGLE)) begin
			state = amc_pkg::AMC_CONV;
		end else begin
			state = amc_pkg::AMC_IDLE;
		end
	end

	// words are taken only from enabled converters while converting or calibrating
	always_comb begin
		for (int c = 0; c < amc_pkg::NCH; c++) begin
			take[c] = fvalid[c] && en_q[c] && pend_q[c] &&
			          ((state == amc_pkg::AMC_CONV) ||
			           (state == amc_pkg::AMC_CAL));
		end
	end
	// only enabled channels owe a word; a disabled one would hold the sequence open
	assign seq_done = ((pend_q & en_q) != 2'h0) && ((pend_q & en_q & ~take) == 2'h0);

	// reference detect pin synchroniser
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ref_sync_q <= 2'h0;
		end else begin
			ref_sync_q <= {ref_sync_q[0], i_ref_missing};
		end
	end

	// mode field: host writes, hardware drops back to idle
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_q <= amc_pkg::MODE_RST;
			rate_q <= amc_pkg::RATE_RST;
		end else if (wr_mode) begin
			// host write wins over the automatic return
			mode_q <= i_wdata[amc_pkg::MODE_LSB +: amc_pkg::MODE_W];
			rate_q <= i_wdata[amc_pkg::RATE_LSB +: amc_pkg::RATE_W];
		end else if (seq_done && (is_cal || (mode_q == CODE_SINGLE))) begin
			mode_q <= CODE_IDLE;
		end
	end

	// per-channel enable bits
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			en_q <= 2'h0;
		end else if (i_wr && (i_addr == amc_pkg::REG_MAIN_CTL)) begin
			en_q[0] <= i_wdata[amc_pkg::EN_BIT];
		end else if (i_wr && (i_addr == amc_pkg::REG_AUX_CTL)) begin
			en_q[1] <= i_wdata[amc_pkg::EN_BIT];
		end
	end

	// owed words: armed by a mode write and held armed in continuous mode, otherwise cleared as words arrive
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_q <= 2'h0;
		end else if (wr_mode) begin
			// any mode write arms both channels, enabled or not
			pend_q <= 2'h3;
		end else if (mode_q == CODE_CONT) begin
			pend_q <= 2'h3;
		end else begin
			pend_q <= pend_q & ~take;
		end
	end

	// calibration error: set wins over the read clear
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			err_q <= 1'b0;
		end else if ((state == amc_pkg::AMC_CAL) && noref && (take != 2'h0)) begin
			err_q <= 1'b1;
		end else if (wr_mode || (i_rd && (i_addr == amc_pkg::REG_STATUS))) begin
			err_q <= 1'b0;
		end
	end

	// data register reads clear the matching ready flag
	assign rd_data[0] = i_rd && (i_addr == amc_pkg::REG_DATA0);
	assign rd_data[1] = i_rd && (i_addr == amc_pkg::REG_DATA1);

	// per-channel result, coefficients and ready flag
	for (genvar c = 0; c < amc_pkg::NCH; c++) begin : g_ch
		logic signed [DW:0]   diff; // filter word minus offset
		logic signed [PW-1:0] prod; // difference times gain
		logic signed [PW-1:0] norm; // product back at unity scale

		// offset first, then gain with unity at the top bit
		assign diff = $signed({1'b0, filt[c]}) - $signed({1'b0, ofs_q[c]});
		assign prod = PW'(diff * $signed({1'b0, gain_q[c]}));
		assign norm = prod >>> (DW - 1);

		// clamp to the unsigned output range
		always_comb begin
			if (norm < 0) begin
				scaled[c] = '0;
			end else if (norm > $signed({{(PW-DW){1'b0}}, {DW{1'b1}}})) begin
				scaled[c] = '1;
			end else begin
				scaled[c] = norm[DW-1:0];
			end
		end

		// conversion result: only normal conversions update it
		always_ff @(posedge i_core_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				data_q[c] <= '0;
			end else if (take[c] && (state == amc_pkg::AMC_CONV)) begin
				data_q[c] <= noref ? '1 : scaled[c];
			end
		end

		// offset coefficient: zero-scale calibration or host write
		always_ff @(posedge i_core_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				ofs_q[c] <= '0;
			end else if (take[c] && (state == amc_pkg::AMC_CAL) && is_zero) begin
				if (!noref) begin
					ofs_q[c] <= filt[c];
				end
			end else if (i_wr && (i_addr == amc_pkg::REG_OFS0 + 4'(c))) begin
				ofs_q[c] <= i_wdata[DW-1:0];
			end
		end

		// gain coefficient: factory value at power-on, then calibration
		always_ff @(posedge i_core_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				gain_q[c] <= (c == 0) ? FACT_GAIN0 : FACT_GAIN1;
			end else if (take[c] && (state == amc_pkg::AMC_CAL) && !is_zero) begin
				if (!noref) begin
					gain_q[c] <= filt[c];
				end
			end else if (i_wr && (i_addr == amc_pkg::REG_GAIN0 + 4'(c))) begin
				gain_q[c] <= i_wdata[DW-1:0];
			end
		end

		// ready flag: set on a finished word, set wins over read clear
		always_ff @(posedge i_core_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				rdy_q[c] <= 1'b0;
			end else if (take[c]) begin
				rdy_q[c] <= 1'b1;
			end else if (rd_data[c] || wr_mode) begin
				rdy_q[c] <= 1'b0;
			end
		end
	end

	// read mux; unmapped indices read zero
	always_comb begin
		rdata_d = 32'h0;
		case (i_addr)
			amc_pkg::REG_MODE: begin
				rdata_d[amc_pkg::MODE_LSB +: amc_pkg::MODE_W] = mode_q;
				rdata_d[amc_pkg::RATE_LSB +: amc_pkg::RATE_W] = rate_q;
			end
			amc_pkg::REG_MAIN_CTL: begin
				rdata_d[amc_pkg::EN_BIT] = en_q[0];
			end
			amc_pkg::REG_AUX_CTL: begin
				rdata_d[amc_pkg::EN_BIT] = en_q[1];
			end
			amc_pkg::REG_STATUS: begin
				rdata_d[amc_pkg::ST_RDY0]  = rdy_q[0];
				rdata_d[amc_pkg::ST_RDY1]  = rdy_q[1];
				rdata_d[amc_pkg::ST_ERR]   = err_q;
				rdata_d[amc_pkg::ST_NOREF] = noref;
			end
			amc_pkg::REG_DATA0: begin
				rdata_d[DW-1:0] = data_q[0];
			end
			amc_pkg::REG_DATA1: begin
				rdata_d[DW-1:0] = data_q[1];
			end
			amc_pkg::REG_OFS0: begin
				rdata_d[DW-1:0] = ofs_q[0];
			end
			amc_pkg::REG_OFS1: begin
				rdata_d[DW-1:0] = ofs_q[1];
			end
			amc_pkg::REG_GAIN0: begin
				rdata_d[DW-1:0] = gain_q[0];
			end
			amc_pkg::REG_GAIN1: begin
				rdata_d[DW-1:0] = gain_q[1];
			end
			default: begin
				rdata_d = 32'h0;
			end
		endcase
	end

	// read data register, answers in every state
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= 32'h0;
		end
	end

	// ready line, forced high in power-down and idle
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdy_n <= 1'b1;
		end else if ((state == amc_pkg::AMC_PWRDN) || (state == amc_pkg::AMC_IDLE)) begin
			o_rdy_n <= 1'b1;
		end else begin
			o_rdy_n <= ~(|(rdy_q & en_q));
		end
	end

	// power, input source and rate controls
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_main_pwr_en  <= 1'b0;
			o_aux_pwr_en   <= 1'b0;
			o_pll_en       <= 1'b0;
			o_int_zero_sel <= 1'b0;
			o_int_full_sel <= 1'b0;
			o_rate_sel     <= amc_pkg::RATE_RST;
		end else begin
			o_main_pwr_en  <= (state != amc_pkg::AMC_PWRDN) && en_q[0];
			o_aux_pwr_en   <= (state != amc_pkg::AMC_PWRDN) && en_q[1];
			o_pll_en       <= (state != amc_pkg::AMC_PWRDN);
			o_int_zero_sel <= (state == amc_pkg::AMC_CAL) && is_int && is_zero;
			o_int_full_sel <= (state == amc_pkg::AMC_CAL) && is_int && !is_zero;
			o_rate_sel     <= (state == amc_pkg::AMC_CAL) ?
			                  amc_pkg::RATE_SLOWEST : rate_q;
		end
	end

	// host interface never powers down
	assign o_host_if_en = 1'b1;

endmodule : amc_ctrl
`default_nettype wire

// >>> amc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module amc_ctrl_chk #(
	parameter logic [2:0] CODE_IZS = 3'h4, // internal zero-scale code
	parameter logic [2:0] CODE_IFS = 3'h5  // internal full-scale code
) (
	input wire logic        i_core_clk,     // core clock
	input wire logic        i_rstn,         // async reset, active low
	input wire logic [3:0]  i_addr,         // register index
	input wire logic [31:0] i_wdata,        // register write data
	input wire logic        i_wr,           // write strobe
	input wire logic        i_rd,           // read strobe
	input wire logic [31:0] o_rdata,        // read data
	input wire logic        o_rdy_n,        // data-ready line
	input wire logic        o_main_pwr_en,  // main converter powered
	input wire logic        o_aux_pwr_en,   // aux converter powered
	input wire logic        o_pll_en,       // pll running
	input wire logic        o_host_if_en,   // host interface alive
	input wire logic        o_int_zero_sel, // internal zero source
	input wire logic        o_int_full_sel, // internal full source
	input wire logic [3:0]  o_rate_sel      // update rate
);
	logic       mode_wr; // a write to the mode register
	logic [2:0] code_q;  // last mode code written
	assign mode_wr = i_wr && (i_addr == amc_pkg::REG_MODE);
	// remember the code so the check two cycles later knows what was asked
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			code_q <= 3'h0;
		end else if (mode_wr) begin
			code_q <= i_wdata[2:0];
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	a_host_if_on: assert property (o_host_if_en)
		else $error("host interface disabled");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside read slot");
	a_pwrdn_quiet: assert property (mode_wr && i_wdata[2:0] == 3'h0 |-> ##2
		(!o_pll_en && !o_main_pwr_en && !o_aux_pwr_en && o_rdy_n)) else $error("power-down not entered");
	a_idle_rdy_high: assert property (mode_wr && i_wdata[2:0] == 3'h1 |-> ##2 o_rdy_n)
		else $error("ready low in idle");
	a_cal_rate_slow: assert property ((o_int_zero_sel || o_int_full_sel)
		|-> o_rate_sel == amc_pkg::RATE_SLOWEST) else $error("calibration not at slowest rate");
	a_cal_src_excl: assert property (!(o_int_zero_sel && o_int_full_sel))
		else $error("both internal sources selected");
	a_cal_src_code: assert property (mode_wr && i_wdata[2] && (o_main_pwr_en || o_aux_pwr_en)
		|-> ##2 (o_rate_sel == amc_pkg::RATE_SLOWEST && o_int_zero_sel == (code_q == CODE_IZS)
		&& o_int_full_sel == (code_q == CODE_IFS))) else $error("calibration source wrong");
	a_main_off: assert property (i_wr && i_addr == amc_pkg::REG_MAIN_CTL && !i_wdata[0]
		|-> ##2 !o_main_pwr_en) else $error("main converter still powered");
	a_pll_with_conv: assert property ((o_main_pwr_en || o_aux_pwr_en) |-> o_pll_en)
		else $error("converter on without pll");
endmodule // amc_ctrl_chk
bind amc_ctrl amc_ctrl_chk #(.CODE_IZS(CODE_IZS), .CODE_IFS(CODE_IFS)) u_chk (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rdy_n(o_rdy_n),
	.o_main_pwr_en(o_main_pwr_en), .o_aux_pwr_en(o_aux_pwr_en), .o_pll_en(o_pll_en),
	.o_host_if_en(o_host_if_en), .o_int_zero_sel(o_int_zero_sel),
	.o_int_full_sel(o_int_full_sel), .o_rate_sel(o_rate_sel));
`default_nettype wire

// >>> amc_filt_model.sv
`timescale 1ns/1ps
`default_nettype none
module amc_filt_model #(
	parameter int DLY = 4 // cycles from request to word
) (
	input  wire logic        i_clk,   // core clock
	input  wire logic        i_send,  // request one word
	input  wire logic [23:0] i_word,  // word to deliver
	output var logic         o_valid, // one-cycle word strobe
	output var logic  [23:0] o_data   // word, scrambled between words
);
	int          cnt = 0;     // cycles left before delivery
	logic [23:0] w_q = 24'h0; // word waiting for delivery
	initial begin
		o_valid = 1'b0;
		o_data  = 24'h5A5A5A;
	end
	// the input is settled before the request, the word follows later
	always @(posedge i_clk) begin
		o_valid <= 1'b0;
		o_data  <= ~o_data;
		if (i_send) begin
			cnt <= DLY;
			w_q <= i_word;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				o_valid <= 1'b1;
				o_data  <= w_q;
			end
		end
	end
endmodule // amc_filt_model
`default_nettype wire

// >>> amc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module amc_ctrl_tb;
	logic        clk = 0, rstn = 0, wr = 0, rd = 0, ref_m = 0; // bench-driven controls
	logic [3:0]  addr = 4'h0;                                   // register index
	logic [31:0] wdata = 32'h0, rdata;                          // register data
	logic [1:0]  snd = 2'h0;                                    // word requests
	logic [23:0] wm = 24'h0, wa = 24'h0, dm, da;                // filter words
	logic        vm, va, rdy_n, mpw, apw, pll, hif, zs, fs;     // strobes and outputs
	logic [3:0]  rate;                                          // update rate out
	int          err_count = 0, n_compared = 0;                 // tallies
	// {mode, main en, aux en, pll, main pwr, aux pwr, zero sel, full sel, rate}
	logic [13:0] rows [9] = '{14'h17C3, 14'h1583, 14'h1343, 14'h1100, 14'h0600,
		14'h25AF, 14'h2B5F, 14'h37CF, 14'h3D8F};
	always #12.5 clk = ~clk;
	amc_ctrl uut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_main_filt_data(dm),
		.i_main_filt_valid(vm), .i_aux_filt_data(da), .i_aux_filt_valid(va),
		.i_ref_missing(ref_m), .o_rdy_n(rdy_n), .o_main_pwr_en(mpw), .o_aux_pwr_en(apw),
		.o_pll_en(pll), .o_host_if_en(hif), .o_int_zero_sel(zs), .o_int_full_sel(fs),
		.o_rate_sel(rate));
	amc_filt_model u_fm (.i_clk(clk), .i_send(snd[0]), .i_word(wm), .o_valid(vm), .o_data(dm));
	amc_filt_model u_fa (.i_clk(clk), .i_send(snd[1]), .i_word(wa), .o_valid(va), .o_data(da));
	// compare one value and tally the outcome
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one-cycle read strobe, data checked in the following cycle
	task rd_reg(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdata & m, exp);
	endtask
	// ask a filter model for one word, then let it settle
	task send(input int ch, input logic [23:0] w);
		@(posedge clk);
		if (ch == 0) wm <= w;
		else wa <= w;
		snd[ch] <= 1'b1;
		@(posedge clk);
		snd <= 2'h0;
		repeat (8) @(posedge clk);
	endtask
	task test_done;
		$display("Compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#500000;
		err_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		// mode and enable table
		foreach (rows[i]) begin
			wr_reg(amc_pkg::REG_MAIN_CTL, {31'h0, rows[i][10]});
			wr_reg(amc_pkg::REG_AUX_CTL, {31'h0, rows[i][9]});
			wr_reg(amc_pkg::REG_MODE, {24'h0, 4'h3, 1'h0, rows[i][13:11]});
			repeat (3) @(posedge clk);
			#1 cmp({26'h0, pll, mpw, apw, zs, fs, rdy_n}, {26'h0, rows[i][8:4], 1'h1});
			if (rows[i][7] || rows[i][6]) cmp({28'h0, rate}, {28'h0, rows[i][3:0]});
		end
		// second reset in mid-run
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(amc_pkg::REG_MODE, 32'h0);
		rd_reg(amc_pkg::REG_GAIN0, 32'h800000);
		rd_reg(amc_pkg::REG_GAIN1, 32'h800000);
		cmp({30'h0, pll, rdy_n}, 32'h1);
		// register access while powered down
		wr_reg(amc_pkg::REG_MAIN_CTL, 32'h1);
		rd_reg(amc_pkg::REG_MAIN_CTL, 32'h1);
		rd_reg(4'hF, 32'h0);
		// zero-scale first, then full-scale on the main converter
		wr_reg(amc_pkg::REG_MODE, 32'h4);
		send(0, 24'h000100);
		rd_reg(amc_pkg::REG_OFS0, 32'h100);
		rd_reg(amc_pkg::REG_MODE, 32'h1);
		rd_reg(amc_pkg::REG_STATUS, 32'h1, 32'h1);
		cmp({31'h0, rdy_n}, 32'h1);
		wr_reg(amc_pkg::REG_MODE, 32'h5);
		send(0, 24'h400000);
		rd_reg(amc_pkg::REG_GAIN0, 32'h400000);
		// system zero-scale on the auxiliary converter only
		wr_reg(amc_pkg::REG_MAIN_CTL, 32'h0);
		wr_reg(amc_pkg::REG_AUX_CTL, 32'h1);
		wr_reg(amc_pkg::REG_MODE, 32'h6);
		send(1, 24'h000020);
		rd_reg(amc_pkg::REG_OFS1, 32'h20);
		rd_reg(amc_pkg::REG_GAIN0, 32'h400000);
		// reference lost during a full-scale calibration
		wr_reg(amc_pkg::REG_MODE, 32'h7);
		ref_m <= 1'b1;
		repeat (4) @(posedge clk);
		send(1, 24'h123456);
		rd_reg(amc_pkg::REG_GAIN1, 32'h800000);
		rd_reg(amc_pkg::REG_STATUS, 32'hC, 32'hC);
		rd_reg(amc_pkg::REG_STATUS, 32'h0, 32'h4);
		@(posedge clk);
		ref_m <= 1'b0;
		// single conversion through offset and gain
		wr_reg(amc_pkg::REG_MAIN_CTL, 32'h1);
		wr_reg(amc_pkg::REG_AUX_CTL, 32'h0);
		wr_reg(amc_pkg::REG_MODE, 32'h3);
		send(0, 24'h001100);
		rd_reg(amc_pkg::REG_DATA0, 32'h800);
		rd_reg(amc_pkg::REG_MODE, 32'h1);
		// continuous conversion, then idle releases the ready line
		wr_reg(amc_pkg::REG_MODE, 32'h2);
		send(0, 24'h000300);
		#1 cmp({31'h0, rdy_n}, 32'h0);
		wr_reg(amc_pkg::REG_MODE, 32'h1);
		repeat (2) @(posedge clk);
		#1 cmp({31'h0, rdy_n}, 32'h1);
		// words offered in power-down leave results alone
		wr_reg(amc_pkg::REG_MODE, 32'h0);
		send(0, 24'h000700);
		rd_reg(amc_pkg::REG_DATA0, 32'h100);
		rd_reg(amc_pkg::REG_OFS0, 32'h100);
		test_done();
	end
endmodule // amc_ctrl_tb
`default_nettype wire
